// file: hw/lcsm_charger.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Off to check on supply and enable
// - No fault: enable blocks, await start delay
// - Feedback above recharge level goes full
// - Low deep-discharge starts switching, precharge
// - Otherwise enter constant current
// - Precharge selects tenth current reference
// - Deep-discharge rise clears timer, enters CC
// - Precharge timeout latches fault
// - Timer off: precharge waits without timeout
// - CV threshold moves to CV, timer kept
// - CC full-charge timeout latches fault
// - Taper in CV resets timer, enters topup
// - CV full-charge timeout latches fault
// - Timer off: taper skips topup to full
// - Topup timeout moves to full battery
// - Full clears timer; low feedback recharges
// - Temperature fault suspends, resumes same state
// - Enable fall shuts down after 2ms
// - Headroom loss shuts down immediately
// - Shutdown stops switching; clamp after 100us
// - Enable collapse shuts down after 10us
// - Status flags encode charger state
// - Full-charge timeout is 1048575 ticks
// - Precharge eighth, topup tenth of timeout
module lcsm_charger
   import lcsm_pkg::*;
#(
   parameter int FULL_TICKS  = FULL_CHARGE_TICKS,
   parameter int START_TICKS = START_DELAY_TICKS,
   parameter int EN_DEB      = EN_DEB_CYC,
   parameter int COMP_DEB    = COMP_DEB_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        safety_timer_osc,
   input  wire lcsm_sense_s sense,
   output lcsm_drive_s      drive,
   output logic             status_flag_low,
   output logic             status_flag_high
);

   initial
   begin
      if (FULL_TICKS < 80 || START_TICKS < 1 || EN_DEB < 1 || COMP_DEB < 1)
         $error("lcsm_charger: parameter out of range");
      // Counters are 21 and 17 bits wide
      if (FULL_TICKS > 2097150 || START_TICKS > 2097150 ||
          EN_DEB > 131071 || COMP_DEB > 131071)
         $error("lcsm_charger: parameter too large for counters");
   end

   // ---------------------------------------------------------------
   // Derived limits
   // ---------------------------------------------------------------
   localparam logic [20:0] T_FULL = 21'(FULL_TICKS);
   localparam logic [20:0] T_PRE  = 21'(FULL_TICKS / 8);
   localparam logic [20:0] T_TOP  = 21'(FULL_TICKS / 10);
   localparam logic [20:0] T_STRT = 21'(START_TICKS);
   localparam logic [16:0] D_EN   = 17'(EN_DEB);
   localparam logic [16:0] D_LOW  = 17'(EN_LOW_DEB_CYC);
   localparam logic [16:0] D_COMP = 17'(COMP_DEB);

   lcsm_state_e state;
   lcsm_state_e next_state;
   logic [20:0] tick_cnt;
   logic        osc_q;
   logic        tick;
   logic        timer_en;
   logic        fault_clr;
   logic [16:0] en_cnt;
   logic [16:0] low_cnt;
   logic [16:0] comp_cnt;
   logic        shut_req;
   logic        in_shut;
   logic        fault_sticky;

   // ---------------------------------------------------------------
   // APB slave, zero wait states
   // ---------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel & penable & (paddr[1:0] != 2'b00);

   wire wr_ctrl = psel & penable & pwrite & (paddr == ADDR_CTRL);

   // Timer enable stands in for the capacitor-vs-reference strap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_en  <= CTRL_RESET[CTRL_TMR_EN];
         fault_clr <= 1'b0;
      end
      else
      begin
         fault_clr <= wr_ctrl & pwdata[CTRL_FLT_CLR];
         if (wr_ctrl)
            timer_en <= pwdata[CTRL_TMR_EN];
      end
   end

   // Read data registered so prdata comes from flip-flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable & ~pwrite)
      begin
         case (paddr)
            ADDR_CTRL:   prdata <= {31'h0, timer_en};
            ADDR_STATUS: prdata <= {24'h0, fault_sticky, in_shut,
                                    status_flag_high, status_flag_low,
                                    state};
            ADDR_TIMER:  prdata <= {11'h0, tick_cnt};
            ADDR_SENSE:  prdata <= {20'h0, sense};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Timer oscillator edge detect (input is synchronous)
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         osc_q <= 1'b0;
      else
         osc_q <= safety_timer_osc;
   end
   assign tick = safety_timer_osc & ~osc_q;

   // ---------------------------------------------------------------
   // Shutdown debounces
   // ---------------------------------------------------------------
   // Enable below falling threshold, 2ms debounce
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_cnt <= 17'h0_0000;
      else if (!sense.enable_off)
         en_cnt <= 17'h0_0000;
      else if (en_cnt != D_EN)
         en_cnt <= en_cnt + 17'h0_0001;
   end

   // Enable collapse, short 10us debounce
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_cnt <= 17'h0_0000;
      else if (!sense.enable_dead)
         low_cnt <= 17'h0_0000;
      else if (low_cnt != D_LOW)
         low_cnt <= low_cnt + 17'h0_0001;
   end

   // Headroom loss needs no debounce
   assign shut_req = (en_cnt == D_EN) | (low_cnt == D_LOW)
                   | sense.headroom_low | ~sense.supply_ok;

   // Compensation clamp waits 100us into shutdown
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         comp_cnt <= 17'h0_0000;
      else if (!in_shut)
         comp_cnt <= 17'h0_0000;
      else if (comp_cnt != D_COMP)
         comp_cnt <= comp_cnt + 17'h0_0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_shut <= 1'b1;
      else if (shut_req)
         in_shut <= 1'b1;
      else if (state == ST_OFF && next_state == ST_CHECK)
         in_shut <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Charger state machine
   // ---------------------------------------------------------------
   function automatic logic is_charging(lcsm_state_e s);
      is_charging = (s == ST_PRE) || (s == ST_CC) ||
                    (s == ST_CV)  || (s == ST_TOP);
   endfunction

   function automatic lcsm_state_e suspend_of(lcsm_state_e s);
      case (s)
         ST_PRE:  suspend_of = ST_SUS_PRE;
         ST_CC:   suspend_of = ST_SUS_CC;
         ST_CV:   suspend_of = ST_SUS_CV;
         default: suspend_of = ST_SUS_TOP;
      endcase
   endfunction

   always_comb
   begin
      next_state = state;
      case (state)
         ST_OFF:
            if (sense.supply_ok && sense.enable_on && !shut_req)
               next_state = ST_CHECK;
         ST_CHECK:
            if (sense.hw_fault)
               next_state = ST_FAULT;
            else if (tick_cnt >= T_STRT)
            begin
               if (sense.fb_above_rechg)
                  next_state = ST_FULL;
               else if (!sense.dd_above_fall)
                  next_state = ST_PRE;
               else
                  next_state = ST_CC;
            end
         ST_PRE:
            if (sense.dd_above_rise)
               next_state = ST_CC;
            else if (timer_en && tick_cnt > T_PRE)
               next_state = ST_FAULT;
         ST_CC:
            if (sense.fb_above_cv)
               next_state = ST_CV;
            else if (timer_en && tick_cnt > T_FULL)
               next_state = ST_FAULT;
         ST_CV:
            if (sense.taper_reached)
               next_state = timer_en ? ST_TOP : ST_FULL;
            else if (timer_en && tick_cnt > T_FULL)
               next_state = ST_FAULT;
         ST_TOP:
            if (!timer_en || tick_cnt > T_TOP)
               next_state = ST_FULL;
         ST_FULL:
            if (!sense.fb_above_rechg)
               next_state = ST_CC;
         ST_SUS_PRE: if (!sense.temp_fault) next_state = ST_PRE;
         ST_SUS_CC:  if (!sense.temp_fault) next_state = ST_CC;
         ST_SUS_CV:  if (!sense.temp_fault) next_state = ST_CV;
         ST_SUS_TOP: if (!sense.temp_fault) next_state = ST_TOP;
         ST_FAULT:
            if (fault_clr)
               next_state = ST_OFF;
         default:
            next_state = ST_OFF;
      endcase
      // Temperature suspend outranks ordinary progress
      if (is_charging(state) && sense.temp_fault)
         next_state = suspend_of(state);
      if (shut_req)
         next_state = ST_OFF;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   // Fault seen since last clear; a new fault beats the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_sticky <= 1'b0;
      else if (next_state == ST_FAULT)
         fault_sticky <= 1'b1;
      else if (fault_clr)
         fault_sticky <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Safety timer, counted in oscillator ticks
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt <= 21'h00_0000;
      else if (next_state != state)
      begin
         // Keep count into CV and across suspend; reset elsewhere
         if ((state == ST_CC && next_state == ST_CV)
             || is_charging(next_state) && suspend_of(next_state) == state
             || suspend_of(state) == next_state)
            tick_cnt <= tick_cnt;
         else
            tick_cnt <= 21'h00_0000;
      end
      else if (tick && tick_cnt != 21'h1F_FFFF &&
               (state == ST_CHECK || is_charging(state)))
         tick_cnt <= tick_cnt + 21'h00_0001;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drive            <= '0;
         status_flag_low  <= 1'b1;
         status_flag_high <= 1'b1;
      end
      else
      begin
         drive.switch_enable     <= is_charging(next_state) & ~shut_req;
         drive.precharge_ref     <= (next_state == ST_PRE);
         drive.input_switch_gate <= shut_req | in_shut;
         drive.comp_clamp        <= in_shut & (comp_cnt == D_COMP);
         drive.internal_enable   <= (next_state != ST_OFF);
         // Flags: off 11, charging 10, full 00, fault/suspend 01
         status_flag_high <= (next_state == ST_OFF) | is_charging(next_state);
         status_flag_low  <= ~(is_charging(next_state) | next_state == ST_FULL);
      end
   end

endmodule : lcsm_charger
`default_nettype wire

// file: hw/lcsm_pkg.sv
package lcsm_pkg;

   // ---------------------------------------------------------------
   // Register map (APB byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TIMER  = 8'h08;
   localparam logic [7:0] ADDR_SENSE  = 8'h0C;

   // Control field positions
   localparam int CTRL_TMR_EN  = 0;
   localparam int CTRL_FLT_CLR = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

   // ---------------------------------------------------------------
   // Timing (pclk 25 MHz)
   // ---------------------------------------------------------------
   localparam int CLK_HZ           = 25_000_000;
   localparam int EN_DEB_US        = 2000;
   localparam int EN_LOW_DEB_US    = 10;
   localparam int COMP_DEB_US      = 100;
   localparam int EN_DEB_CYC       = EN_DEB_US * (CLK_HZ / 1_000_000);
   localparam int EN_LOW_DEB_CYC   = EN_LOW_DEB_US * (CLK_HZ / 1_000_000);
   localparam int COMP_DEB_CYC     = COMP_DEB_US * (CLK_HZ / 1_000_000);
   localparam int FULL_CHARGE_TICKS = 1048575;
   localparam int START_DELAY_TICKS = 16;

   // Charger states
   typedef enum logic [3:0] {
      ST_OFF, ST_CHECK, ST_PRE, ST_CC, ST_CV, ST_TOP, ST_FULL,
      ST_FAULT, ST_SUS_PRE, ST_SUS_CC, ST_SUS_CV, ST_SUS_TOP
   } lcsm_state_e;

   // Comparator results from the analog front end
   typedef struct packed {
      logic supply_ok;      // internal supply above 4.2V
      logic enable_on;      // enable above 1.25V
      logic enable_off;     // enable below 1.09V
      logic enable_dead;    // enable below 0.64V
      logic headroom_low;   // supply-to-sense below 1.95V
      logic hw_fault;
      logic fb_above_rechg; // feedback above 1.19V
      logic fb_above_cv;    // feedback above 1.219V
      logic dd_above_fall;  // deep-discharge at or above 1.25V
      logic dd_above_rise;  // deep-discharge above 1.26V
      logic taper_reached;
      logic temp_fault;
   } lcsm_sense_s;

   // Power stage controls
   typedef struct packed {
      logic switch_enable;
      logic precharge_ref;
      logic input_switch_gate;   // high: gate pull-down active
      logic comp_clamp;
      logic internal_enable;
   } lcsm_drive_s;

endpackage : lcsm_pkg

// file: dv/lcsm_charger_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lcsm_charger_monitor
   import lcsm_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire lcsm_sense_s sense,
   input wire lcsm_drive_s drive,
   input wire logic        status_flag_low,
   input wire logic        status_flag_high
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic [1:0] flg;
   logic       up;
   // Up means no supply, headroom or enable-off shutdown can mask the expected move
   assign flg = {status_flag_high, status_flag_low};
   assign up  = sense.supply_ok && !sense.headroom_low && !sense.enable_off;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_prech_drive: assert property (
      drive.precharge_ref |-> drive.switch_enable && flg == 2'b10)
      else $error("precharge reference outside charging");
   a_switch_flags: assert property (
      drive.switch_enable |-> flg == 2'b10)
      else $error("switching without charging flags");
   a_off_quiet: assert property (
      flg == 2'b11 |-> !drive.switch_enable && !drive.precharge_ref)
      else $error("off flags while driving");
   a_gate_stops: assert property (
      drive.input_switch_gate |-> !drive.switch_enable)
      else $error("gate pull-down while switching");
   a_clamp_wait: assert property (
      $rose(drive.input_switch_gate) |=> !drive.comp_clamp [*8])
      else $error("clamp came before its debounce");
   a_shut_gate: assert property (
      sense.headroom_low |-> ##[1:4]
      (drive.input_switch_gate && !drive.switch_enable))
      else $error("headroom loss did not shut down");
   a_supply_off: assert property (
      !sense.supply_ok |-> ##[1:4] flg == 2'b11)
      else $error("charger not off without supply");
   a_rechg_leave: assert property (
      flg == 2'b00 && up && !sense.fb_above_rechg && !sense.temp_fault
      |-> ##[1:4] flg == 2'b10)
      else $error("full state did not recharge");
   a_temp_susp: assert property (
      flg == 2'b10 && sense.temp_fault && up |-> ##[1:4] flg == 2'b01)
      else $error("temperature fault did not suspend");
   c_resume: cover property (flg == 2'b01 ##1 flg == 2'b10);
   c_clamp: cover property ($rose(drive.comp_clamp));
   c_prech: cover property ($rose(drive.precharge_ref));
endmodule // lcsm_charger_monitor

bind lcsm_charger lcsm_charger_monitor u_mon (
   .pclk(pclk),
   .presetn(presetn),
   .sense(sense),
   .drive(drive),
   .status_flag_low(status_flag_low),
   .status_flag_high(status_flag_high)
);
`default_nettype wire

// file: dv/lcsm_front_end.sv
`timescale 1ns/100ps
`default_nettype none
module lcsm_front_end
   import lcsm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire lcsm_sense_s want,
   output lcsm_sense_s      sense,
   output logic             safety_timer_osc
);
   // ---------------------------------------------------------------
   // Comparators and timer oscillator
   // ---------------------------------------------------------------
   // Comparators settle one cycle after the battery moves
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sense <= '0;
      else
         sense <= want;
   end
   // Free-running oscillator, one tick per two cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         safety_timer_osc <= 1'b0;
      else
         safety_timer_osc <= ~safety_timer_osc;
   end
endmodule // lcsm_front_end
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import lcsm_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct {
      logic [7:0]  a;
      logic [31:0] e;
      logic [31:0] m;
      logic [6:0]  pm;
      logic [6:0]  p;
   } lcsm_note_s;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        osc;
   lcsm_sense_s want    = '0;
   lcsm_sense_s sense;
   lcsm_drive_s drive;
   logic        fl;
   logic        fh;
   logic        on      = 1'b0;
   lcsm_note_s  q[$];
   lcsm_note_s  nt;
   logic [31:0] rd;
   int          n_errors     = 0;
   int          total_checks = 0;
   // Short counts keep the full-charge run near 1600 cycles
   always #20 pclk = ~pclk;
   lcsm_charger #(.FULL_TICKS(800), .EN_DEB(20), .COMP_DEB(10)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .safety_timer_osc(osc),
      .sense(sense), .drive(drive), .status_flag_low(fl),
      .status_flag_high(fh));
   lcsm_front_end u_fe (.pclk(pclk), .presetn(presetn), .want(want),
      .sense(sense), .safety_timer_osc(osc));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e, m,
                      input logic [6:0] pm, p);
      q.push_back('{a, e, m, pm, p});
      on = 1'b1;
      apb(1'b0, a, 32'h0);
      on = 1'b0;
   endtask
   // Flags, switching and precharge select expected per state
   function automatic logic [6:0] pins(input lcsm_state_e s);
      case (s)
         ST_OFF: return 7'b1100000;
         ST_PRE: return 7'b1011000;
         ST_CC, ST_CV, ST_TOP: return 7'b1010000;
         ST_FULL: return 7'b0000000;
         default: return 7'b0100000;
      endcase
   endfunction
   // Poll for a state under a bound, then check it
   task automatic go(input lcsm_state_e s, input int lim);
      int k;
      logic [6:0] p;
      k = 0;
      p = pins(s);
      do
      begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         k++;
      end
      while (rd[3:0] !== s && k < lim);
      chk(ADDR_STATUS, {26'h0, p[6:5], s}, 32'h3F, 7'h78, p);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Checker of noted results
   // ---------------------------------------------------------------
   // Each completed checked read takes the oldest note
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && on && q.size() > 0)
      begin
         nt = q.pop_front();
         total_checks++;
         if ((prdata & nt.m) !== nt.e)
         begin
            n_errors++;
            $display("wrong value reg %h exp %h got %h", nt.a, nt.e, prdata);
         end
         if (({fh, fl, drive} & nt.pm) !== nt.p)
         begin
            n_errors++;
            $display("wrong value pins exp %h got %h", nt.p, {fh, fl, drive});
         end
      end
   end
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   // Hang guard, well beyond the 4600 or so cycles the tests need
   initial
   begin
      cyc(20000);
      n_errors++;
      report_and_stop;
   end
   initial
   begin
      void'($urandom(62));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(ADDR_CTRL, CTRL_RESET, 32'hFFFFFFFF, 7'h00, 7'h00);
      chk(8'($urandom_range(63, 4) * 4), 32'h0, 32'hFFFFFFFF, 7'h0, 7'h0);
      go(ST_OFF, 1);
      want <= 12'hC00;
      go(ST_PRE, 40);
      cyc(180);
      go(ST_PRE, 1);
      go(ST_FAULT, 15);
      want <= 12'hC20;
      apb(1'b1, ADDR_CTRL, 32'h3);
      go(ST_FULL, 40);
      want <= 12'hC08;
      go(ST_CC, 10);
      cyc(900);
      want <= 12'hC18;
      go(ST_CV, 10);
      cyc(600);
      go(ST_CV, 1);
      go(ST_FAULT, 40);
      want <= 12'hC08;
      apb(1'b1, ADDR_CTRL, 32'h3);
      go(ST_CC, 40);
      want <= 12'hC18;
      go(ST_CV, 10);
      want <= 12'hC1A;
      go(ST_TOP, 10);
      want <= 12'hC1B;
      go(ST_SUS_TOP, 10);
      want <= 12'hC3A;
      go(ST_TOP, 10);
      cyc(125);
      go(ST_TOP, 1);
      go(ST_FULL, 20);
      apb(1'b1, ADDR_CTRL, 32'h0);
      want <= 12'hC18;
      go(ST_CV, 20);
      cyc(1700);
      go(ST_CV, 1);
      // Feedback stays above recharge level once the battery is full
      want <= 12'hC3A;
      go(ST_FULL, 3);
      want <= 12'hC9A;
      go(ST_OFF, 3);
      cyc(15);
      chk(ADDR_STATUS, 32'h30, 32'h30, 7'h7E, 7'h66);
      want <= 12'hC00;
      go(ST_PRE, 40);
      cyc(300);
      go(ST_PRE, 1);
      want <= 12'hC01;
      go(ST_SUS_PRE, 10);
      want <= 12'hC00;
      go(ST_PRE, 10);
      want <= 12'hC0C;
      go(ST_CC, 10);
      want <= 12'hA0C;
      cyc(10);
      go(ST_CC, 1);
      go(ST_OFF, 10);
      // Enable collapse alone, on its fixed short debounce
      want <= 12'hC00;
      go(ST_PRE, 40);
      want <= 12'h900;
      cyc(230);
      go(ST_PRE, 1);
      go(ST_OFF, 15);
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
